// ---- rtl/hjio_pkg.sv ----
// constants, register map and types of the handler judgment port
package hjio_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ACQ = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_PANEL = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_INPUTS = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PINS = 5'h1c;
  // control fields
  localparam int CTRL_BIN_MODE = 0;
  localparam int CTRL_MEASURE_START_IN_RISE = 1;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
  // result word fields
  localparam int RES_PRIMARY_ABOVE_OUT = 0;
  localparam int RES_PRIMARY_BELOW_OUT = 1;
  localparam int RES_MAIN_IN = 2;
  localparam int RES_SUB_IN = 3;
  localparam int RES_MAIN_JDG = 4;
  localparam int RES_SUB_JDG = 5;
  localparam int RES_FAULT_LSB = 8;
  localparam int FAULT_W = 5;
  localparam int RES_BIN_LSB = 16;
  localparam int PIN_W = 5;
  // status and mask fields
  localparam int ST_MEASURE_START_IN = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_DONE = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  // input test fields
  localparam int IN_MEASURE_START_IN = 0;
  localparam int IN_STROBE = 1;
  localparam int IN_SEL_LSB = 8;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 20;
  localparam int DONE_PULSE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DONE_CYC = (DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  typedef enum {DN_IDLE, DN_SETTLE, DN_PULSE} hjio_done_st_t;
endpackage : hjio_pkg

// ---- rtl/hjio_link_if.sv ----
// internal carrier between the port top and its input and judgment modules
`timescale 1ns/10ps
interface hjio_link_if #(parameter int PANEL_W = 7);
  import hjio_pkg::*;
  logic measure_start_in_rise;
  logic measure_start_in_raw;
  logic [PANEL_W-1:0] sel_n;
  logic strobe_n;
  logic measure_start_in_evt;
  logic load_evt;
  logic [PANEL_W-1:0] panel;
  logic apply;
  logic [DATA_W-1:0] result;
  logic bin_mode;
  logic [PIN_W-1:0] pins_n;
  logic fault_n;
  modport main_mp(output measure_start_in_rise, measure_start_in_raw, sel_n, strobe_n, apply, result, bin_mode,
    input measure_start_in_evt, load_evt, panel, pins_n, fault_n);
  modport watch_mp(input measure_start_in_rise, measure_start_in_raw, sel_n, strobe_n,
    output measure_start_in_evt, load_evt, panel);
  modport judge_mp(input apply, result, bin_mode, output pins_n, fault_n);
endinterface : hjio_link_if

// ---- rtl/hjio_input_watch.sv ----
// trigger edge detection and panel select sampling
`timescale 1ns/10ps
module hjio_input_watch #(parameter int PANEL_W = 7) (
  input wire logic clk_i,
  input wire logic nrst_i,
  hjio_link_if.watch_mp lnk
);
  import hjio_pkg::*;
  logic measure_start_in_prev, next_measure_start_in_prev;
  logic strobe_prev, next_strobe_prev;
  logic primed, next_primed;
  logic [PANEL_W-1:0] panel, next_panel;

  // edge detection; nothing fires until one sample has been seen after reset
  always_comb begin
    next_measure_start_in_prev = lnk.measure_start_in_raw;
    next_strobe_prev = lnk.strobe_n;
    next_primed = 1'b1;
    lnk.measure_start_in_evt = primed & (lnk.measure_start_in_rise ? (lnk.measure_start_in_raw & ~measure_start_in_prev)
                                           : (~lnk.measure_start_in_raw & measure_start_in_prev));
    lnk.load_evt = primed & strobe_prev & ~lnk.strobe_n;
    next_panel = panel;
    if (lnk.load_evt) begin
      next_panel = ~lnk.sel_n;
    end
  end

  // input history registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      measure_start_in_prev <= 1'b0;
      strobe_prev <= 1'b1;
      primed <= 1'b0;
      panel <= '0;
    end else begin
      measure_start_in_prev <= next_measure_start_in_prev;
      strobe_prev <= next_strobe_prev;
      primed <= next_primed;
      panel <= next_panel;
    end
  end

  assign lnk.panel = panel;
endmodule : hjio_input_watch

// ---- rtl/hjio_judge_out.sv ----
// maps a result word onto the active-low judgment and fault pins
`timescale 1ns/10ps
module hjio_judge_out (
  input wire logic clk_i,
  input wire logic nrst_i,
  hjio_link_if.judge_mp lnk
);
  import hjio_pkg::*;
  logic [PIN_W-1:0] pins_n, next_pins_n;
  logic fault_n, next_fault_n;
  logic main_j, sub_j, and_pass;

  // combined pass over whichever parameters were judged
  always_comb begin
    main_j = lnk.result[RES_MAIN_JDG];
    sub_j = lnk.result[RES_SUB_JDG];
    and_pass = (main_j | sub_j) & (~main_j | lnk.result[RES_MAIN_IN])
             & (~sub_j | lnk.result[RES_SUB_IN]);
    next_pins_n = pins_n;
    next_fault_n = fault_n;
    if (lnk.apply) begin
      next_fault_n = ~(|lnk.result[RES_FAULT_LSB +: FAULT_W]);
      if (lnk.bin_mode) begin
        next_pins_n = ~lnk.result[RES_BIN_LSB +: PIN_W];
      end else begin
        next_pins_n = ~{1'b0, and_pass, lnk.result[RES_SUB_IN],
                        lnk.result[RES_PRIMARY_BELOW_OUT], lnk.result[RES_PRIMARY_ABOVE_OUT]};
      end
    end
  end

  // pin registers, all released high at reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pins_n <= '1;
      fault_n <= 1'b1;
    end else begin
      pins_n <= next_pins_n;
      fault_n <= next_fault_n;
    end
  end

  assign lnk.pins_n = pins_n;
  assign lnk.fault_n = fault_n;
endmodule : hjio_judge_out

// ---- rtl/hjio_port.sv ----
// handler judgment port top: bus slave, done sequencing and interrupts
// Functional notes
// - A trigger edge starts a measurement and a strobed panel number requests a setup.
// - Completion and judgment results go out on their own handler port lines.
// - The fault line is low while any sampling, contact, high-Z, regulation or limit fault.
// - Main high and low verdicts drive active-low pins that carry bin results in bin mode.
// - The sub in-range verdict drives an active-low pin shared with a bin result.
// - The combined-pass pin is the AND of both in-range verdicts, active low.
// - With only one parameter judged, combined pass follows that parameter's verdict.
// - An input line counts as asserted when low and shows by name in the input test.
// - Measurement done pulses low only after every judgment pin holds its final value.
// - Conversion done falls high to low when acquisition ends; the sample may then change.
`timescale 1ns/10ps
module hjio_port #(
  parameter int PANEL_W = 7
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [hjio_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [hjio_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [hjio_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic MEASURE_START_IN_I,
  input wire logic [PANEL_W-1:0] SETUP_SELECT_N_I,
  input wire logic SETUP_LOAD_STROBE_N_I,
  output logic MEASURE_START_O,
  output logic PANEL_LOAD_O,
  output logic [PANEL_W-1:0] PANEL_NUM_O,
  output logic FAULT_N_O,
  output logic CLASS_OUT_1_N_O,
  output logic CLASS_OUT_3_N_O,
  output logic CLASS_OUT_5_N_O,
  output logic CLASS_OUT_7_N_O,
  output logic CLASS_OUT_9_N_O,
  output logic MEASURE_DONE_OUT_N_O,
  output logic CONV_DONE_N_O,
  output logic IRQ_O
);
  import hjio_pkg::*;

  // elaboration checks on what the logic can serve
  if (PANEL_W < 1 || PANEL_W > 8) begin : g_bad_panel_w
    $error("PANEL_W must be 1 to 8");
  end
  if (SETTLE_CYC < 1 || DONE_CYC < 1 || DONE_CYC >= (1 << CNT_W)
      || SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_timing
    $error("done timing does not fit the counter");
  end

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] DONE_LAST = CNT_W'(DONE_CYC - 1);

  // byte-enable merge of a write into a stored word
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v, input logic [3:0] be);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  hjio_link_if #(.PANEL_W(PANEL_W)) lnk ();

  hjio_input_watch #(.PANEL_W(PANEL_W)) u_watch (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .lnk(lnk.watch_mp)
  );

  hjio_judge_out u_judge (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .lnk(lnk.judge_mp)
  );

  // bus state
  logic ack, next_ack;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic req, wr_go;
  // register state
  logic [DATA_W-1:0] ctrl, next_ctrl;
  logic [DATA_W-1:0] result, next_result;
  logic [IRQ_W-1:0] status, next_status;
  logic [IRQ_W-1:0] mask, next_mask;
  logic [IRQ_W-1:0] st_set, st_clr;
  // sequencing state
  hjio_done_st_t dn_st, next_dn_st;
  logic [CNT_W-1:0] dn_cnt, next_dn_cnt;
  logic done_n, next_done_n;
  logic conv_n, next_conv_n;
  logic start_p, next_start_p;
  logic load_p, next_load_p;
  logic apply, done_evt, acq_wr;
  logic [DATA_W-1:0] inputs_word, pins_word;

  // handler inputs into the watcher, result word, mode and apply into the judge; trigger polarity chosen by software
  assign lnk.measure_start_in_raw = MEASURE_START_IN_I;
  assign lnk.measure_start_in_rise = ctrl[CTRL_MEASURE_START_IN_RISE];
  assign lnk.sel_n = SETUP_SELECT_N_I;
  assign lnk.strobe_n = SETUP_LOAD_STROBE_N_I;
  assign lnk.result = next_result;
  assign lnk.bin_mode = ctrl[CTRL_BIN_MODE];
  assign lnk.apply = apply;

  // request decode: one wait cycle, answer on the second edge
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign wr_go = AVS_WRITE_I & ack;
  assign AVS_WAITREQUEST_O = req & ~ack;
  assign apply = wr_go && (AVS_ADDRESS_I == OFS_RESULT);
  assign acq_wr = wr_go && (AVS_ADDRESS_I == OFS_ACQ) && AVS_BYTEENABLE_I[0]
                  && AVS_WRITEDATA_I[0];

  // input test word: asserted lines read as ones
  always_comb begin
    inputs_word = '0;
    inputs_word[IN_MEASURE_START_IN] = ~MEASURE_START_IN_I;
    inputs_word[IN_STROBE] = ~SETUP_LOAD_STROBE_N_I;
    inputs_word[IN_SEL_LSB +: PANEL_W] = ~SETUP_SELECT_N_I;
  end

  // live pin readback
  always_comb begin
    pins_word = '0;
    pins_word[PIN_W-1:0] = lnk.pins_n;
    pins_word[8] = lnk.fault_n;
    pins_word[9] = done_n;
    pins_word[10] = conv_n;
  end

  // bus slave and register file next values
  always_comb begin
    next_ack = req & ~ack;
    next_rdata = rdata;
    next_ctrl = ctrl;
    next_result = result;
    next_mask = mask;
    st_clr = '0;
    if (req && !ack && AVS_READ_I) begin
      case (AVS_ADDRESS_I)
        OFS_CTRL: next_rdata = ctrl;
        OFS_RESULT: next_rdata = result;
        OFS_STATUS: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, status};
        OFS_MASK: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, mask};
        OFS_PANEL: next_rdata = {{(DATA_W-PANEL_W){1'b0}}, lnk.panel};
        OFS_INPUTS: next_rdata = inputs_word;
        OFS_PINS: next_rdata = pins_word;
        default: next_rdata = '0;
      endcase
    end
    if (wr_go) begin
      case (AVS_ADDRESS_I)
        OFS_CTRL: next_ctrl = be_merge(ctrl, AVS_WRITEDATA_I, AVS_BYTEENABLE_I)
                              & 32'h0000_0003;
        OFS_RESULT: next_result = be_merge(result, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        OFS_STATUS: st_clr = AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[IRQ_W-1:0] : '0;
        OFS_MASK: begin
          if (AVS_BYTEENABLE_I[0]) begin
            next_mask = AVS_WRITEDATA_I[IRQ_W-1:0];
          end
        end
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // bus and register flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ack <= 1'b0;
      rdata <= '0;
      ctrl <= CTRL_RST;
      result <= RESULT_RST;
      mask <= IRQ_RST;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      result <= next_result;
      mask <= next_mask;
    end
  end

  // done sequencing: settle after the pins update, then pulse done low
  always_comb begin
    next_dn_st = dn_st;
    next_dn_cnt = dn_cnt;
    next_done_n = 1'b1;
    done_evt = 1'b0;
    case (dn_st)
      DN_IDLE: begin
        next_dn_cnt = '0;
      end
      DN_SETTLE: begin
        next_dn_cnt = dn_cnt + 1'b1;
        if (dn_cnt == SETTLE_LAST) begin
          next_dn_st = DN_PULSE;
          next_dn_cnt = '0;
          next_done_n = 1'b0;
        end
      end
      DN_PULSE: begin
        next_done_n = 1'b0;
        next_dn_cnt = dn_cnt + 1'b1;
        if (dn_cnt == DONE_LAST) begin
          next_dn_st = DN_IDLE;
          next_dn_cnt = '0;
          next_done_n = 1'b1;
          done_evt = 1'b1;
        end
      end
      default: begin
        next_dn_st = DN_IDLE;
        next_dn_cnt = '0;
      end
    endcase
    if (apply) begin
      next_dn_st = DN_SETTLE;
      next_dn_cnt = '0;
      next_done_n = 1'b1;
    end
  end

  // conversion done and strobes toward the measurement core
  always_comb begin
    next_conv_n = conv_n;
    next_start_p = lnk.measure_start_in_evt;
    next_load_p = lnk.load_evt;
    if (lnk.measure_start_in_evt) begin
      next_conv_n = 1'b1;
    end
    if (acq_wr) begin
      next_conv_n = 1'b0;
    end
  end

  // sticky events; a set in the clear cycle wins
  always_comb begin
    st_set = '0;
    st_set[ST_MEASURE_START_IN] = lnk.measure_start_in_evt;
    st_set[ST_LOAD] = lnk.load_evt;
    st_set[ST_DONE] = done_evt;
    next_status = (status & ~st_clr) | st_set;
  end

  // sequencing, strobe and status flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dn_st <= DN_IDLE;
      dn_cnt <= '0;
      done_n <= 1'b1;
      conv_n <= 1'b1;
      start_p <= 1'b0;
      load_p <= 1'b0;
      status <= IRQ_RST;
    end else begin
      dn_st <= next_dn_st;
      dn_cnt <= next_dn_cnt;
      done_n <= next_done_n;
      conv_n <= next_conv_n;
      start_p <= next_start_p;
      load_p <= next_load_p;
      status <= next_status;
    end
  end

  assign FAULT_N_O = lnk.fault_n;
  assign CLASS_OUT_1_N_O = lnk.pins_n[0];
  assign CLASS_OUT_3_N_O = lnk.pins_n[1];
  assign CLASS_OUT_5_N_O = lnk.pins_n[2];
  assign CLASS_OUT_7_N_O = lnk.pins_n[3];
  assign CLASS_OUT_9_N_O = lnk.pins_n[4];
  assign MEASURE_DONE_OUT_N_O = done_n;
  assign CONV_DONE_N_O = conv_n;
  // core-side strobes and panel number
  assign MEASURE_START_O = start_p;
  assign PANEL_LOAD_O = load_p;
  assign PANEL_NUM_O = lnk.panel;
  assign AVS_READDATA_O = rdata;
  // level interrupt from unmasked sticky bits
  assign IRQ_O = |(status & mask);
endmodule : hjio_port

// ---- tb/hjio_handler_model.sv ----
// behavioural handler driving the trigger and panel select pins
`timescale 1ns/10ps
module hjio_handler_model #(
  parameter int PANEL_W = 7
) (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic load_i,
  input wire logic [PANEL_W-1:0] panel_i,
  output logic measure_start_in_o,
  output logic [PANEL_W-1:0] sel_n_o,
  output logic strobe_n_o
);
  int tcnt = 0;
  int lcnt = 0;
  // idle lines stay high, nothing asserted
  initial begin
    measure_start_in_o = 1'b1;
    sel_n_o = '1;
    strobe_n_o = 1'b1;
  end
  // trigger pulled low three cycles, both edges shown
  always @(posedge clk_i) begin
    if (fire_i) tcnt <= 3;
    else if (tcnt > 0) tcnt <= tcnt - 1;
    measure_start_in_o <= !(fire_i || tcnt > 1);
  end
  // select settles three cycles before the strobe and stays held
  always @(posedge clk_i) begin
    if (load_i) sel_n_o <= ~panel_i;
    if (load_i) lcnt <= 1;
    else if (lcnt > 0) lcnt <= (lcnt == 6) ? 0 : lcnt + 1;
    strobe_n_o <= !(lcnt >= 3 && lcnt < 6);
  end
endmodule : hjio_handler_model

// ---- tb/hjio_port_checker.sv ----
// concurrent checks on the handler judgment port pins
`timescale 1ns/10ps
module hjio_port_checker import hjio_pkg::*; #(
  parameter int PANEL_W = 7
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic MEASURE_START_IN_I,
  input wire logic [PANEL_W-1:0] SETUP_SELECT_N_I,
  input wire logic MEASURE_START_O,
  input wire logic PANEL_LOAD_O,
  input wire logic [PANEL_W-1:0] PANEL_NUM_O,
  input wire logic FAULT_N_O,
  input wire logic CLASS_OUT_1_N_O,
  input wire logic CLASS_OUT_3_N_O,
  input wire logic CLASS_OUT_5_N_O,
  input wire logic CLASS_OUT_7_N_O,
  input wire logic CLASS_OUT_9_N_O,
  input wire logic MEASURE_DONE_OUT_N_O,
  input wire logic CONV_DONE_N_O
);
  logic wr_ok, wr_res, wr_acq;
  logic [4:0] pins;
  // accepted writes and the packed class pins
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign wr_res = wr_ok && AVS_ADDRESS_I == OFS_RESULT;
  assign wr_acq = wr_ok && AVS_ADDRESS_I == OFS_ACQ && AVS_WRITEDATA_I[0];
  assign pins = {CLASS_OUT_9_N_O, CLASS_OUT_7_N_O, CLASS_OUT_5_N_O, CLASS_OUT_3_N_O,
    CLASS_OUT_1_N_O};
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  chk_pins_hold: assert property (!$stable(pins) |-> $past(wr_res))
    else $error("class pins moved without a result write");
  chk_fault_hold: assert property (!$stable(FAULT_N_O) |-> $past(wr_res))
    else $error("fault line moved without a result write");
  chk_done_settle: assert property ($fell(MEASURE_DONE_OUT_N_O) |->
    ($past(wr_res, 3) || $past(wr_res, 4)) && $stable(pins))
    else $error("done fell without settled verdicts");
  chk_done_width: assert property ($fell(MEASURE_DONE_OUT_N_O) |->
    (!MEASURE_DONE_OUT_N_O) [*8] ##2 !MEASURE_DONE_OUT_N_O ##1 MEASURE_DONE_OUT_N_O)
    else $error("done pulse width wrong");
  chk_start_single: assert property (MEASURE_START_O |=> !MEASURE_START_O)
    else $error("start pulse longer than one cycle");
  chk_start_cause: assert property ($rose(MEASURE_START_O) |->
    $past(MEASURE_START_IN_I, 1) != $past(MEASURE_START_IN_I, 2) ||
    $past(MEASURE_START_IN_I, 2) != $past(MEASURE_START_IN_I, 3) ||
    $past(MEASURE_START_IN_I, 3) != $past(MEASURE_START_IN_I, 4))
    else $error("start pulse without trigger edge");
  chk_panel_num: assert property (PANEL_LOAD_O |-> PANEL_NUM_O == ~SETUP_SELECT_N_I)
    else $error("panel number differs from select lines");
  chk_conv_fall: assert property ($fell(CONV_DONE_N_O) |-> $past(wr_acq))
    else $error("conversion done fell without acquisition end");
  // main scenarios reached
  cov_done: cover property ($fell(MEASURE_DONE_OUT_N_O));
  cov_load: cover property (PANEL_LOAD_O);
  cov_start: cover property (MEASURE_START_O);
endmodule : hjio_port_checker
bind hjio_port hjio_port_checker #(.PANEL_W(PANEL_W)) hjio_port_checker_i (.CLK_I, .NRST_I,
  .AVS_ADDRESS_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_WAITREQUEST_O, .MEASURE_START_IN_I,
  .SETUP_SELECT_N_I, .MEASURE_START_O, .PANEL_LOAD_O, .PANEL_NUM_O, .FAULT_N_O,
  .CLASS_OUT_1_N_O, .CLASS_OUT_3_N_O, .CLASS_OUT_5_N_O, .CLASS_OUT_7_N_O, .CLASS_OUT_9_N_O,
  .MEASURE_DONE_OUT_N_O, .CONV_DONE_N_O);

// ---- tb/tb_hjio_port.sv ----
// self-checking bench for the handler judgment port
`timescale 1ns/10ps
module tb_hjio_port;
  import hjio_pkg::*;
  logic clk, nrst, rd, wr, fire, load, measure_start_in, strobe_n;
  logic mstart, pload, fault_n, done_n, conv_n, irq, wait_o;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wd, rdata, q;
  logic [6:0] pnl, sel_n, pnum;
  wire [4:0] pins;
  int mismatches = 0;
  int comparisons = 0;
  int starts = 0;
  hjio_handler_model hjio_handler_model_i (.clk_i(clk), .fire_i(fire), .load_i(load),
    .panel_i(pnl), .measure_start_in_o(measure_start_in), .sel_n_o(sel_n), .strobe_n_o(strobe_n));
  hjio_port hjio_port_i (.CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .MEASURE_START_IN_I(measure_start_in), .SETUP_SELECT_N_I(sel_n),
    .SETUP_LOAD_STROBE_N_I(strobe_n), .MEASURE_START_O(mstart), .PANEL_LOAD_O(pload),
    .PANEL_NUM_O(pnum), .FAULT_N_O(fault_n), .CLASS_OUT_1_N_O(pins[0]),
    .CLASS_OUT_3_N_O(pins[1]), .CLASS_OUT_5_N_O(pins[2]), .CLASS_OUT_7_N_O(pins[3]),
    .CLASS_OUT_9_N_O(pins[4]), .MEASURE_DONE_OUT_N_O(done_n), .CONV_DONE_N_O(conv_n),
    .IRQ_O(irq));
  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts measurement start pulses
  always @(posedge clk) begin
    if (mstart === 1'b1) starts <= starts + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wait_o !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rchk
  task automatic wait_done();
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("done_low", 32'h0, 32'(done_n));
    repeat (12) @(posedge clk);
  endtask : wait_done
  task automatic t_reset();
    chk("pins_rst", 32'h1f, 32'(pins));
    chk("fault_rst", 32'h1, 32'(fault_n));
    rchk("ctrl_rst", OFS_CTRL, CTRL_RST);
    rchk("result_rst", OFS_RESULT, RESULT_RST);
    $display("test reset done");
  endtask : t_reset
  task automatic t_compare();
    logic [31:0] rw [6] = '{32'h11, 32'h12, 32'h3c, 32'h14, 32'h28, 32'h34};
    logic [4:0] ex [6] = '{5'h1e, 5'h1d, 5'h13, 5'h17, 5'h13, 5'h1f};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFS_RESULT, rw[i]);
      wait_done();
      chk("cmp_pins", 32'(ex[i]), 32'(pins));
    end
    rchk("status_done", OFS_STATUS, 32'h4);
    bus(1'b1, OFS_STATUS, 32'h4);
    $display("test compare done");
  endtask : t_compare
  task automatic t_bin();
    bus(1'b1, OFS_CTRL, 32'h1);
    rchk("ctrl_bin", OFS_CTRL, 32'h1);
    bus(1'b1, OFS_RESULT, 32'h0015_0000);
    wait_done();
    chk("bin_pins", 32'h0a, 32'(pins));
    bus(1'b1, OFS_CTRL, 32'h0);
    $display("test bin done");
  endtask : t_bin
  task automatic t_fault();
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_RESULT, 32'h100 << i);
      wait_done();
      chk("fault_on", 32'h0, 32'(fault_n));
    end
    bus(1'b1, OFS_RESULT, 32'h0);
    wait_done();
    chk("fault_off", 32'h1, 32'(fault_n));
    // pin readback: class pins idle, fault, done and conversion done all high
    rchk("pins_reg", OFS_PINS, 32'h0000_071f);
    $display("test fault done");
  endtask : t_fault
  task automatic fire_chk(input string nm);
    int s0;
    s0 = starts;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
    chk(nm, s0 + 1, starts);
  endtask : fire_chk
  task automatic t_trigger();
    bus(1'b1, OFS_MASK, 32'h1);
    bus(1'b1, OFS_ACQ, 32'h1);
    @(posedge clk);
    chk("conv_low", 32'h0, 32'(conv_n));
    fire_chk("starts_fall");
    chk("conv_back", 32'h1, 32'(conv_n));
    chk("irq_set", 32'h1, 32'(irq));
    bus(1'b1, OFS_STATUS, 32'h1);
    @(posedge clk);
    chk("irq_clr", 32'h0, 32'(irq));
    bus(1'b1, OFS_CTRL, 32'h2);
    fire_chk("starts_rise");
    bus(1'b1, OFS_CTRL, 32'h0);
    $display("test trigger done");
  endtask : t_trigger
  task automatic t_panel();
    pnl <= 7'h55;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    repeat (12) @(posedge clk);
    chk("panel_num", 32'h55, 32'(pnum));
    bus(1'b1, OFS_PANEL, 32'h0);
    rchk("panel_reg", OFS_PANEL, 32'h55);
    rchk("inputs_reg", OFS_INPUTS, 32'h5500);
    $display("test panel done");
  endtask : t_panel
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // reset, then the scenarios in order
  initial begin
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wd = '0;
    fire = 1'b0;
    load = 1'b0;
    pnl = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_compare();
    t_bin();
    t_fault();
    t_trigger();
    t_panel();
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : tb_hjio_port
